// File: rtl/dcc_top.sv
/*
 * Dual comparator control: mode register, input routing, result bits,
 * port pin multiplexing, change flag with mismatch latch, interrupt gating.
 * Assumes an APB master on pclk, the analog comparators and port pads outside.
 */
// The APB register port was left to the implementer.
// Functional notes
// - Three-bit mode field selects eight configurations
// - Result bit 1 when plus above minus
// - Result bit 0 when plus below minus
// - Result bits are read-only
// - Mode 010 routes reference to plus inputs
// - Mode 110 drives raw results onto pins 3,4
// - Direction bits still enable pins 3,4
// - Direction register governs comparator pin direction
// - Analog pins read zero from port data
// - Results ignored during mode settling window
// - Flag sets when results differ from latch
// - Flag write 0 clears, 1 sets
// - Interrupt needs all three enables set
// - Flag sets regardless of enables
// - Change coinciding with control read may vanish
// - Control register access relatches results
// - Persisting mismatch keeps re-setting flag
// - Reset puts mode selector at 000
// - Mode 111 powers both comparators off
// - Enabled change wakes device, control unchanged
`timescale 1ns/1ps
module dcc_top #(
    parameter int unsigned SETTLE_CYC = dcc_pkg::SETTLE_CYC
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [dcc_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic [1:0]                  cmp_raw,
    output dcc_pkg::dcc_route_s              cmp_route,
    output logic      [4:0]                  analog_sel,
    input  wire logic [4:0]                  porta_in,
    output logic      [4:0]                  porta_out,
    output logic      [4:0]                  porta_oe,
    output logic                             irq,
    output logic                             wake
);

    // ****************************************
    // Declarations
    // ****************************************
    dcc_pkg::dcc_bus_state_e state_ff;
    dcc_pkg::dcc_bus_state_e nxt_state;
    dcc_pkg::dcc_route_s     route_ff;
    dcc_pkg::dcc_route_s     nxt_route;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_rdata;
    logic        pslverr_ff;
    logic        nxt_err;
    logic [2:0]  mode_ff;
    logic        switch_ff;
    logic [1:0]  latched_ff;
    logic        flag_ff;
    logic        cie_ff;
    logic        peripheral_irq_enable_ff;
    logic        gie_ff;
    logic [4:0]  dir_ff;
    logic [4:0]  pdata_ff;
    logic [4:0]  amask_ff;
    logic [4:0]  oe_ff;
    logic        irq_ff;
    logic        wake_ff;
    logic [1:0]  res_sync;
    logic [1:0]  res_eff;
    logic        settling;
    logic        mismatch;
    logic        done;
    logic        wr;
    logic        hit_ctrl;
    logic        mode_write;

    // ****************************************
    // APB slave
    // ****************************************
    // One load cycle before pready so that prdata comes from a flop.
    assign done     = psel && penable && (state_ff == dcc_pkg::DCC_ST_ANSWER);
    assign wr       = done && pwrite;
    assign hit_ctrl = done && (paddr == dcc_pkg::ADDR_CMP_CONTROL);

    always_comb begin
        nxt_state = dcc_pkg::DCC_ST_IDLE;
        case (state_ff)
            dcc_pkg::DCC_ST_IDLE: begin
                if (psel && penable) begin
                    nxt_state = dcc_pkg::DCC_ST_LOAD;
                end
            end
            dcc_pkg::DCC_ST_LOAD:   nxt_state = dcc_pkg::DCC_ST_ANSWER;
            dcc_pkg::DCC_ST_ANSWER: nxt_state = dcc_pkg::DCC_ST_IDLE;
            default:                nxt_state = dcc_pkg::DCC_ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= dcc_pkg::DCC_ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_comb begin
        nxt_rdata = 32'h0;
        nxt_err   = 1'b0;
        case (paddr)
            dcc_pkg::ADDR_CMP_CONTROL: begin
                nxt_rdata[dcc_pkg::RES2_BIT]   = res_eff[1];
                nxt_rdata[dcc_pkg::RES1_BIT]   = res_eff[0];
                nxt_rdata[dcc_pkg::SWITCH_BIT] = switch_ff;
                nxt_rdata[2:0]                 = mode_ff;
            end
            dcc_pkg::ADDR_PERIPH_FLAG:   nxt_rdata[dcc_pkg::FLAG_BIT] = flag_ff;
            dcc_pkg::ADDR_PERIPH_ENABLE: nxt_rdata[dcc_pkg::ENABLE_BIT] = cie_ff;
            dcc_pkg::ADDR_IRQ_CONTROL: begin
                nxt_rdata[dcc_pkg::GIE_BIT]  = gie_ff;
                nxt_rdata[dcc_pkg::PERIPHERAL_IRQ_ENABLE_BIT] = peripheral_irq_enable_ff;
            end
            dcc_pkg::ADDR_PORTA_DIR:     nxt_rdata[4:0] = dir_ff;
            dcc_pkg::ADDR_PORT_DATA:     nxt_rdata[4:0] = porta_in & ~amask_ff;
            default:                     nxt_err = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= 32'h0;
            pslverr_ff <= 1'b0;
        end else if (state_ff == dcc_pkg::DCC_ST_LOAD) begin
            prdata_ff  <= pwrite ? 32'h0 : nxt_rdata;
            pslverr_ff <= nxt_err;
        end else if (state_ff == dcc_pkg::DCC_ST_ANSWER) begin
            prdata_ff  <= 32'h0;
            pslverr_ff <= 1'b0;
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = (state_ff == dcc_pkg::DCC_ST_ANSWER);
    assign pslverr = pslverr_ff;

    // ****************************************
    // Control register and mode settling
    // ****************************************
    assign mode_write = wr && hit_ctrl && (pwdata[2:0] != mode_ff);

    // Result bits have no write path at all
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ff   <= dcc_pkg::MODE_RST;
            switch_ff <= 1'b0;
        end else if (wr && hit_ctrl) begin
            mode_ff   <= pwdata[2:0];
            switch_ff <= pwdata[dcc_pkg::SWITCH_BIT];
        end
    end

    dcc_settle_timer #(
        .CYCLES (SETTLE_CYC),
        .CNT_W  (16)
    ) u_settle (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (mode_write),
        .busy    (settling)
    );

    dcc_sync2 #(
        .W (2)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (cmp_raw),
        .sync_out (res_sync)
    );

    // A powered-down comparator reads low
    assign res_eff = res_sync & route_ff.cmp_on;

    // ****************************************
    // Analog routing
    // ****************************************
    always_comb begin
        nxt_route               = '0;
        nxt_route.vref_noninv   = (mode_ff == dcc_pkg::MODE_VREF);
        nxt_route.c1_minus_pin3 = switch_ff &&
                                  ((mode_ff == dcc_pkg::MODE_MUX4) ||
                                   (mode_ff == dcc_pkg::MODE_VREF));
        nxt_route.c2_minus_pin2 = switch_ff && (mode_ff == dcc_pkg::MODE_VREF);
        nxt_route.cmp_on        = dcc_pkg::cmp_power(mode_ff);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            route_ff <= '0;
            amask_ff <= 5'h0f;
        end else begin
            route_ff <= nxt_route;
            amask_ff <= dcc_pkg::analog_mask(mode_ff);
        end
    end

    assign cmp_route  = route_ff;
    assign analog_sel = amask_ff;

    // ****************************************
    // Port pins
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_ff   <= dcc_pkg::DIR_RST;
            pdata_ff <= 5'h0;
            oe_ff    <= 5'h0;
        end else begin
            if (wr && paddr == dcc_pkg::ADDR_PORTA_DIR) begin
                dir_ff <= pwdata[4:0];
            end
            if (wr && paddr == dcc_pkg::ADDR_PORT_DATA) begin
                pdata_ff <= pwdata[4:0];
            end
            oe_ff <= ~dir_ff;
        end
    end

    // Pins 3/4 carry the raw comparator outputs unclocked, so they can glitch
    assign porta_out[2:0] = pdata_ff[2:0];
    assign porta_out[3]   = (mode_ff == dcc_pkg::MODE_PINOUT) ? cmp_raw[0] : pdata_ff[3];
    assign porta_out[4]   = (mode_ff == dcc_pkg::MODE_PINOUT) ? cmp_raw[1] : pdata_ff[4];
    assign porta_oe       = oe_ff;

    // ****************************************
    // Change detection and interrupt
    // ****************************************
    // During settling the latch tracks the results, so no false change is seen
    assign mismatch = !settling && (res_eff != latched_ff);

    // Latching on the access edge absorbs a change seen in that same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latched_ff <= 2'h0;
        end else if (hit_ctrl || settling) begin
            latched_ff <= res_eff;
        end
    end

    // Set wins over a software clear while the mismatch stands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_ff <= 1'b0;
        end else if (mismatch && !hit_ctrl) begin
            flag_ff <= 1'b1;
        end else if (wr && paddr == dcc_pkg::ADDR_PERIPH_FLAG) begin
            flag_ff <= pwdata[dcc_pkg::FLAG_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cie_ff  <= 1'b0;
            peripheral_irq_enable_ff <= 1'b0;
            gie_ff  <= 1'b0;
        end else begin
            if (wr && paddr == dcc_pkg::ADDR_PERIPH_ENABLE) begin
                cie_ff <= pwdata[dcc_pkg::ENABLE_BIT];
            end
            if (wr && paddr == dcc_pkg::ADDR_IRQ_CONTROL) begin
                gie_ff  <= pwdata[dcc_pkg::GIE_BIT];
                peripheral_irq_enable_ff <= pwdata[dcc_pkg::PERIPHERAL_IRQ_ENABLE_BIT];
            end
        end
    end

    // Wake needs only the local enable; the core gates the rest after waking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff  <= 1'b0;
            wake_ff <= 1'b0;
        end else begin
            irq_ff  <= flag_ff && cie_ff && peripheral_irq_enable_ff && gie_ff;
            wake_ff <= flag_ff && cie_ff;
        end
    end

    assign irq  = irq_ff;
    assign wake = wake_ff;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_mode_write_taken: assert property (
        wr && hit_ctrl |=> mode_ff == $past(pwdata[2:0]) ##1 route_ff.cmp_on
            == dcc_pkg::cmp_power($past(pwdata[2:0], 2)))
        else $error("mode field not taken from write");

    a_flag_on_change: assert property (
        mismatch && !hit_ctrl |=> flag_ff)
        else $error("flag not set by mismatch");

    a_flag_sw_clear: assert property (
        wr && paddr == dcc_pkg::ADDR_PERIPH_FLAG && !pwdata[dcc_pkg::FLAG_BIT]
            && !mismatch |=> !flag_ff)
        else $error("flag not cleared by write of zero");

    a_irq_gating: assert property (
        ##1 irq_ff == $past(flag_ff && cie_ff && peripheral_irq_enable_ff && gie_ff))
        else $error("interrupt not gated by all enables");

    a_relatch_access: assert property (
        hit_ctrl |=> latched_ff == $past(res_eff) && (!mismatch || res_eff != $past(res_eff)))
        else $error("control access did not relatch");

    a_settle_quiet: assert property (
        mode_write |=> settling [*8])
        else $error("mode change not followed by settling");

    a_vref_route: assert property (
        mode_ff == dcc_pkg::MODE_VREF |=> route_ff.vref_noninv && route_ff.cmp_on == 2'h3)
        else $error("reference not routed in mode 010");

    a_pin_mux: assert property (
        mode_ff == dcc_pkg::MODE_PINOUT |-> porta_out[4:3] == {cmp_raw[1], cmp_raw[0]})
        else $error("pins 3 and 4 do not carry raw results");

    a_oe_from_dir: assert property (
        ##2 porta_oe == ~$past(dir_ff))
        else $error("output enable not following direction");

    a_mode_off: assert property (
        mode_ff == dcc_pkg::MODE_OFF |=> route_ff.cmp_on == 2'h0 && res_eff == 2'h0)
        else $error("comparators not off in mode 111");

endmodule

// File: rtl/dcc_pkg.sv
/*
 * Shared constants, types and mode tables for the dual comparator control block.
 * Assumes a 40 MHz APB clock and a 32-bit APB data path.
 */
package dcc_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam int unsigned ADDR_W            = 12;
    localparam logic [9:0]  IDX_PORT_DATA     = 10'h005;
    localparam logic [9:0]  IDX_IRQ_CONTROL   = 10'h00b;
    localparam logic [9:0]  IDX_PERIPH_FLAG   = 10'h00c;
    localparam logic [9:0]  IDX_CMP_CONTROL   = 10'h01f;
    localparam logic [9:0]  IDX_PORTA_DIR     = 10'h085;
    localparam logic [9:0]  IDX_PERIPH_ENABLE = 10'h08c;
    localparam logic [11:0] ADDR_PORT_DATA     = {IDX_PORT_DATA, 2'h0};
    localparam logic [11:0] ADDR_IRQ_CONTROL   = {IDX_IRQ_CONTROL, 2'h0};
    localparam logic [11:0] ADDR_PERIPH_FLAG   = {IDX_PERIPH_FLAG, 2'h0};
    localparam logic [11:0] ADDR_CMP_CONTROL   = {IDX_CMP_CONTROL, 2'h0};
    localparam logic [11:0] ADDR_PORTA_DIR     = {IDX_PORTA_DIR, 2'h0};
    localparam logic [11:0] ADDR_PERIPH_ENABLE = {IDX_PERIPH_ENABLE, 2'h0};

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int unsigned MODE_LSB    = 0;
    localparam int unsigned SWITCH_BIT  = 3;
    localparam int unsigned RES1_BIT    = 6;
    localparam int unsigned RES2_BIT    = 7;
    localparam int unsigned FLAG_BIT    = 6;
    localparam int unsigned ENABLE_BIT  = 6;
    localparam int unsigned PERIPHERAL_IRQ_ENABLE_BIT    = 6;
    localparam int unsigned GIE_BIT     = 7;
    localparam int unsigned PINS        = 5;
    localparam logic [2:0]  MODE_RST    = 3'h0;
    localparam logic [4:0]  DIR_RST     = 5'h1f;

    // Mode selector values with fixed meaning
    localparam logic [2:0]  MODE_RESET  = 3'h0;
    localparam logic [2:0]  MODE_MUX4   = 3'h1;
    localparam logic [2:0]  MODE_VREF   = 3'h2;
    localparam logic [2:0]  MODE_PINOUT = 3'h6;
    localparam logic [2:0]  MODE_OFF    = 3'h7;

    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned SETTLE_NS     = 10000;
    localparam int unsigned SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        DCC_ST_IDLE   = 3'b001,
        DCC_ST_LOAD   = 3'b010,
        DCC_ST_ANSWER = 3'b100
    } dcc_bus_state_e;

    // Analog switch controls sent to the comparator macro
    typedef struct packed {
        logic       vref_noninv;
        logic       c1_minus_pin3;
        logic       c2_minus_pin2;
        logic [1:0] cmp_on;
    } dcc_route_s;

    // Pins that the mode claims as analog inputs, bit n = porta_pinN
    function automatic logic [4:0] analog_mask(input logic [2:0] mode);
        case (mode)
            3'h0, 3'h1, 3'h2, 3'h4: analog_mask = 5'h0f;
            3'h3, 3'h6:             analog_mask = 5'h07;
            3'h5:                   analog_mask = 5'h06;
            default:                analog_mask = 5'h00;
        endcase
    endfunction

    function automatic logic [1:0] cmp_power(input logic [2:0] mode);
        case (mode)
            3'h0, 3'h7: cmp_power = 2'h0;
            3'h5:       cmp_power = 2'h2;
            default:    cmp_power = 2'h3;
        endcase
    endfunction

endpackage

// File: rtl/dcc_sync2.sv
/*
 * Two-flop synchroniser for the raw comparator outputs.
 * Assumes the inputs may toggle at any time relative to pclk.
 */
`timescale 1ns/1ps
module dcc_sync2 #(
    parameter int unsigned W = 2
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule

// File: rtl/dcc_settle_timer.sv
/*
 * Busy window after a comparator mode change.
 * Assumes start is a one-cycle pulse; a new start restarts the window.
 */
`timescale 1ns/1ps
module dcc_settle_timer #(
    parameter int unsigned CYCLES = 400,
    parameter int unsigned CNT_W  = 12
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic start,
    output logic      busy
);
    logic [CNT_W-1:0] count_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff <= '0;
        end else if (start) begin
            count_ff <= CNT_W'(CYCLES);
        end else if (count_ff != '0) begin
            count_ff <= count_ff - CNT_W'(1);
        end
    end

    assign busy = (count_ff != '0);
endmodule

// File: tb/dcc_far_model.sv
/*
 * Far side of the comparator block: two comparators and the port pads.
 * Assumes the bench gives input levels in millivolts and external pad levels.
 */
`timescale 1ns/1ps
module dcc_far_model #(
    parameter int unsigned VREF_MV = 2500
) (
    input  wire logic [1:0][15:0]    plus_mv,
    input  wire logic [1:0][15:0]    minus_mv,
    input  wire dcc_pkg::dcc_route_s route,
    input  wire logic [4:0]          pad_ext,
    input  wire logic [4:0]          porta_out,
    input  wire logic [4:0]          porta_oe,
    output logic      [1:0]          cmp_raw,
    output logic      [4:0]          porta_in
);
    // ****************************************
    // Comparators and pads
    // ****************************************
    logic [1:0][15:0] pos;
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            pos[i]     = route.vref_noninv ? 16'(VREF_MV) : plus_mv[i];
            // Unpowered comparator gives low rather than holding its last level
            cmp_raw[i] = route.cmp_on[i] & (pos[i] > minus_mv[i]);
        end
    end
    assign porta_in = (porta_oe & porta_out) | (~porta_oe & pad_ext);
endmodule

// File: tb/dual_comparator_control_test.sv
/*
 * Self-checking bench for dcc_top: APB master, scoreboard, far-side model.
 * Assumes SETTLE_CYC is shortened to 8 so mode changes settle quickly.
 */
`timescale 1ns/1ps
module dual_comparator_control_test;
    // ****************************************
    // Signals
    // ****************************************
    localparam int unsigned SETTLE = 8;
    logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, wake;
    logic [11:0]         paddr;
    logic [31:0]         pwdata, prdata;
    logic [1:0]          cmp_raw;
    dcc_pkg::dcc_route_s cmp_route;
    logic [4:0]          analog_sel, porta_in, porta_out, porta_oe, pad_ext;
    logic [1:0][15:0]    plus_mv, minus_mv;
    logic [33:0]         expq[$];
    logic [33:0]         mon_e;
    logic                sw;
    int                  fail_count, n_compared, cyc;

    dcc_top #(.SETTLE_CYC(SETTLE)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cmp_raw(cmp_raw), .cmp_route(cmp_route),
        .analog_sel(analog_sel), .porta_in(porta_in), .porta_out(porta_out),
        .porta_oe(porta_oe), .irq(irq), .wake(wake));
    dcc_far_model far (.plus_mv(plus_mv), .minus_mv(minus_mv), .route(cmp_route),
        .pad_ext(pad_ext), .porta_out(porta_out), .porta_oe(porta_oe), .cmp_raw(cmp_raw),
        .porta_in(porta_in));

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [4:0] amask(input int m);
        case (m)
            0, 1, 2, 4: return 5'h0f;
            3, 6:       return 5'h07;
            5:          return 5'h06;
            default:    return 5'h00;
        endcase
    endfunction
    function automatic logic [1:0] pwr(input int m);
        return (m == 0 || m == 7) ? 2'h0 : (m == 5) ? 2'h2 : 2'h3;
    endfunction
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Starts one edge later than the last release, so no signal is driven twice at one edge
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        input logic err);
        int n;
        expq.push_back({wr, err, d});
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // Request stands until the rising edge at which pready is seen high
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) fail_count++;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, e, 1'b0);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 1'b0);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask

    // ****************************************
    // Clock, timeout and scoreboard
    // ****************************************
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            summarize();
        end
    end
    always @(negedge pclk) begin
        if (pready === 1'b1) begin
            if (expq.size() == 0) check(32'h1, 32'h0);
            else begin
                mon_e = expq.pop_front();
                check(pslverr, mon_e[32]);
                if (!mon_e[33]) check(prdata, mon_e[31:0]);
            end
        end
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
        pwdata = 32'h0; pad_ext = 5'h0;
        plus_mv = {16'd3000, 16'd3000}; minus_mv = {16'd2800, 16'd2800};
        void'($urandom(69));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(dcc_pkg::ADDR_CMP_CONTROL, 32'h0);
        rd(dcc_pkg::ADDR_PORTA_DIR, 32'h1f);
        wait_n(1);
        check(porta_oe, 5'h0);
        check(analog_sel, 5'h0f);
        $display("test reset done");
        // Interrupt enables stay clear across mode changes, as software must keep them
        for (int m = 0; m < 8; m++) begin
            sw = 1'($urandom);
            @(posedge pclk);
            pad_ext <= 5'($urandom);
            wr(dcc_pkg::ADDR_CMP_CONTROL, {24'h0, 4'hc, sw, 3'(m)});
            wait_n(SETTLE + 8);
            check(analog_sel, amask(m));
            check(cmp_route.cmp_on, pwr(m));
            check(cmp_route.vref_noninv, m == 2);
            if (m == 1 || m == 2) check(cmp_route.c1_minus_pin3, sw);
            if (m == 2) check(cmp_route.c2_minus_pin2, sw);
            rd(dcc_pkg::ADDR_CMP_CONTROL, {24'h0, (m == 2) ? 2'h0 : pwr(m), 2'h0, sw, 3'(m)});
            rd(dcc_pkg::ADDR_PORT_DATA, {27'h0, pad_ext & ~amask(m)});
        end
        $display("test modes done");
        wr(dcc_pkg::ADDR_CMP_CONTROL, 32'h06);
        wr(dcc_pkg::ADDR_PORTA_DIR, 32'h07);
        wait_n(SETTLE + 8);
        check(porta_oe, 5'h18);
        check(porta_out[4:3], 2'h3);
        @(posedge pclk);
        minus_mv[0] <= 16'd3500;
        @(negedge pclk);
        check(porta_out[3], 1'b0);
        wr(dcc_pkg::ADDR_PORT_DATA, 32'h15);
        wait_n(1);
        check(porta_out[2:0], 3'h5);
        wr(dcc_pkg::ADDR_PORTA_DIR, 32'h1f);
        wait_n(2);
        check(porta_oe, 5'h0);
        $display("test pin output done");
        wr(dcc_pkg::ADDR_CMP_CONTROL, 32'h03);
        wait_n(SETTLE + 8);
        rd(dcc_pkg::ADDR_CMP_CONTROL, 32'h83);
        @(posedge pclk);
        minus_mv <= {16'd3500, 16'd2800};
        wait_n(4);
        rd(dcc_pkg::ADDR_CMP_CONTROL, 32'h43);
        wr(dcc_pkg::ADDR_PERIPH_FLAG, 32'h0);
        rd(dcc_pkg::ADDR_PERIPH_FLAG, 32'h0);
        @(posedge pclk);
        minus_mv[0] <= 16'd3500;
        wait_n(6);
        rd(dcc_pkg::ADDR_PERIPH_FLAG, 32'h40);
        check(irq, 1'b0);
        wr(dcc_pkg::ADDR_PERIPH_FLAG, 32'h0);
        wait_n(2);
        rd(dcc_pkg::ADDR_PERIPH_FLAG, 32'h40);
        rd(dcc_pkg::ADDR_CMP_CONTROL, 32'h03);
        wr(dcc_pkg::ADDR_PERIPH_FLAG, 32'h0);
        rd(dcc_pkg::ADDR_PERIPH_FLAG, 32'h0);
        wr(dcc_pkg::ADDR_PERIPH_FLAG, 32'h40);
        rd(dcc_pkg::ADDR_PERIPH_FLAG, 32'h40);
        wr(dcc_pkg::ADDR_PERIPH_ENABLE, 32'h40);
        wait_n(3);
        check(wake, 1'b1);
        check(irq, 1'b0);
        wr(dcc_pkg::ADDR_IRQ_CONTROL, 32'hc0);
        wait_n(3);
        check(irq, 1'b1);
        wr(dcc_pkg::ADDR_PERIPH_FLAG, 32'h0);
        wait_n(3);
        check(irq, 1'b0);
        $display("test change flag done");
        xfer(1'b0, 12'hffc, 32'h0, 1'b1);
        xfer(1'b1, 12'hffc, 32'hff, 1'b1);
        rd(dcc_pkg::ADDR_CMP_CONTROL, 32'h03);
        wait_n(2);
        $display("test unmapped done");
        summarize();
    end
endmodule
